// ---- rtl/rxtm_params.svh ----
// Purpose: offsets, field positions, reset values of the rx header and test select bank
// Assumes: 8-bit register file on a plain strobe port
// Notes: definitions only
`ifndef RXTM_PARAMS_SVH
`define RXTM_PARAMS_SVH
`define RXTM_OFF_HDR2 8'h48
`define RXTM_OFF_HDR1 8'h49
`define RXTM_OFF_HDR0 8'h4a
`define RXTM_OFF_PLEN 8'h4b
`define RXTM_OFF_AUX 8'h4f
`define RXTM_OFF_APROBE 8'h50
`define RXTM_OFF_DPROBE 8'h51
`define RXTM_RST_HDR 8'h00
`define RXTM_RST_PLEN 8'hff
`define RXTM_RST_AUX 6'h00
`define RXTM_RST_APROBE 5'h00
`define RXTM_RST_DPROBE 7'h00
`define RXTM_AUX_MASK 8'h3f
`define RXTM_APROBE_MASK 8'h1f
`define RXTM_DPROBE_MASK 8'h7f
`define RXTM_SCAN_BIT 6
`define RXTM_ATB_RSV_LO 5'h0b
`define RXTM_ATB_RSV_HI 5'h11
`endif

// ---- rtl/rxtm_pkg.sv ----
// Purpose: types for the rx header and test select bank
// Assumes: nothing
// Notes: capture carrier from the packet handler
package rxtm_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] hdr2;
		logic [7:0] hdr1;
		logic [7:0] hdr0;
		logic [7:0] len_byte;
	} rxtm_capture_s;
	typedef logic [7:0] rxtm_byte_t;
endpackage

// ---- rtl/rxtm_sync.sv ----
// Purpose: three-stage synchroniser for a pin input
// Assumes: one clock
// Notes: output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module rxtm_sync (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic pin_out
);
	logic s1_r, s2_r, s3_r, out_r;
	// ---------------------------------------------------------------
	// chain; first stage read by the second only
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			out_r <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				out_r <= s3_r;
			end
		end
	end
	assign pin_out = out_r;
endmodule
`default_nettype wire

// ---- rtl/rxtm_regs.sv ----
// Purpose: rx header, rx length, aux converter and probe select registers
// Assumes: packet handler gives a one-cycle capture; fixed length flag and programmed
//   length come from the packet configuration elsewhere
// Notes: read data one cycle after the read strobe, zero otherwise
`include "rxtm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module rxtm_regs (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire rxtm_pkg::rxtm_capture_s rx_capture,
	input wire logic fixed_len_mode,
	input wire logic [7:0] programmed_len,
	output logic [7:0] expected_rx_len,
	output logic [5:0] aux_converter_bits,
	output logic [4:0] analog_sel,
	output logic analog_route_valid,
	output logic [5:0] digital_sel,
	input wire logic general_pin_zero,
	output logic scan_mode,
	output logic scan_shift_enable
);
	import rxtm_pkg::*;

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	rxtm_byte_t hdr2_r, hdr1_r, hdr0_r, plen_r, rdata_r;
	logic [5:0] aux_r;
	logic [4:0] aprobe_r;
	logic [6:0] dprobe_r;
	logic pin_sync;

	// address decode
	wire sel_aux = (reg_addr == `RXTM_OFF_AUX);
	wire sel_ap = (reg_addr == `RXTM_OFF_APROBE);
	wire sel_dp = (reg_addr == `RXTM_OFF_DPROBE);
	wire [7:0] read_mux;
	assign read_mux = (reg_addr == `RXTM_OFF_HDR2) ? hdr2_r :
		(reg_addr == `RXTM_OFF_HDR1) ? hdr1_r :
		(reg_addr == `RXTM_OFF_HDR0) ? hdr0_r :
		(reg_addr == `RXTM_OFF_PLEN) ? plen_r :
		sel_aux ? {2'b00, aux_r} :
		sel_ap ? {3'b000, aprobe_r} :
		sel_dp ? {1'b0, dprobe_r} : 8'h00;

	// ---------------------------------------------------------------
	// capture of received header and length
	// ---------------------------------------------------------------
	// header capture
	// no bus write path reaches these
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hdr2_r <= `RXTM_RST_HDR;
			hdr1_r <= `RXTM_RST_HDR;
			hdr0_r <= `RXTM_RST_HDR;
			plen_r <= `RXTM_RST_PLEN;
		end else if (rx_capture.valid) begin
			hdr2_r <= rx_capture.hdr2;
			hdr1_r <= rx_capture.hdr1;
			hdr0_r <= rx_capture.hdr0;
			plen_r <= rx_capture.len_byte;
		end
	end

	// ---------------------------------------------------------------
	// writable registers
	// ---------------------------------------------------------------
	// reserved bits masked off on write
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			aux_r <= `RXTM_RST_AUX;
			aprobe_r <= `RXTM_RST_APROBE;
			dprobe_r <= `RXTM_RST_DPROBE;
		end else if (reg_wr) begin
			if (sel_aux) begin
				aux_r <= reg_wdata[5:0];
			end
			if (sel_ap) begin
				aprobe_r <= reg_wdata[4:0];
			end
			if (sel_dp) begin
				dprobe_r <= reg_wdata[6:0];
			end
		end
	end

	// read data stands one cycle only
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= reg_rd ? read_mux : 8'h00;
		end
	end
	assign reg_rdata = rdata_r;

	// ---------------------------------------------------------------
	// outputs: expected length, aux converter bits, analog and digital mux selects, scan
	// ---------------------------------------------------------------
	// length register is trusted only with fixed length off
	// expected length picks the programmed value in fixed mode
	assign expected_rx_len = fixed_len_mode ? programmed_len : plen_r;
	assign aux_converter_bits = aux_r;
	// reserved codes and code zero flagged, only defined nonzero codes routed
	assign analog_route_valid = (aprobe_r != 5'h00) &&
		!((aprobe_r >= `RXTM_ATB_RSV_LO) && (aprobe_r <= `RXTM_ATB_RSV_HI));
	assign analog_sel = analog_route_valid ? aprobe_r : 5'h00;
	// selection forwarded to the test bus
	assign digital_sel = dprobe_r[5:0];

	// pin is asynchronous, so it is resynchronised
	rxtm_sync u_pin_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin_in(general_pin_zero),
		.pin_out(pin_sync)
	);
	// scan enable takeover of general pin zero
	assign scan_mode = dprobe_r[`RXTM_SCAN_BIT];
	assign scan_shift_enable = scan_mode & pin_sync;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// one capture pulse from the packet handler
	sequence s_capture;
		rx_capture.valid;
	endsequence
	// bus write aimed at the digital select register
	sequence s_dsel_write;
		reg_wr && sel_dp;
	endsequence
	// pin seen high out of reset for as long as the synchroniser needs;
	// rst_n is part of it so that a release does not start a false attempt
	sequence s_pin_high_held;
		(rst_n && general_pin_zero) [*4];
	endsequence
	// pin seen low out of reset for the same span
	sequence s_pin_low_held;
		(rst_n && !general_pin_zero) [*4];
	endsequence

	// header bytes load together and clear at reset
	a_header_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_capture |=> (hdr2_r == $past(rx_capture.hdr2)) &&
		(hdr1_r == $past(rx_capture.hdr1)) &&
		(hdr0_r == $past(rx_capture.hdr0)))
		else $error("header byte not captured");
	a_header_reset: assert property (@(posedge core_clk)
		!rst_n |=> hdr2_r == 8'h00 && hdr1_r == 8'h00 && hdr0_r == 8'h00)
		else $error("header reset not zero");
	// hdr1_r moves only on a capture; hdr2_r, hdr0_r and plen_r never on a bus write without a capture
	a_header_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!rx_capture.valid |=> $stable(hdr1_r))
		else $error("header changed without capture");
	a_ro_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && !rx_capture.valid) |=> $stable(hdr2_r) && $stable(hdr0_r) && $stable(plen_r))
		else $error("read-only register written");
	// length byte load and its all-ones reset
	a_len_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_capture |=> plen_r == $past(rx_capture.len_byte))
		else $error("length not captured");
	a_len_reset: assert property (@(posedge core_clk)
		!rst_n |=> plen_r == 8'hff)
		else $error("length reset not all ones");
	a_expected_len: assert property (@(posedge core_clk) disable iff (!rst_n)
		expected_rx_len == (fixed_len_mode ? programmed_len : plen_r))
		else $error("expected length wrong source");
	// reserved codes route nothing, defined codes pass through
	a_analog_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
		(aprobe_r >= 5'h0b && aprobe_r <= 5'h11) |-> !analog_route_valid && analog_sel == 5'h00)
		else $error("reserved analog code routed");
	a_analog_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
		((aprobe_r != 5'h00 && aprobe_r < 5'h0b) || aprobe_r > 5'h11) |->
		analog_route_valid && analog_sel == aprobe_r)
		else $error("defined analog code not routed");
	// scan bit follows the bus, and the pin reaches scan enable only in scan mode
	a_scan_takeover: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_dsel_write |=> scan_mode == $past(reg_wdata[`RXTM_SCAN_BIT]))
		else $error("scan enable not taken over");
	a_scan_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		!scan_mode |-> !scan_shift_enable)
		else $error("scan enable outside scan mode");
	a_pin_settle: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_pin_high_held |=> pin_sync)
		else $error("pin high not passed through");
	a_pin_release: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_pin_low_held |=> !pin_sync)
		else $error("pin low not passed through");
	// digital select written from the bus
	a_dsel_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_dsel_write |=> digital_sel == $past(reg_wdata[5:0]))
		else $error("digital select not written");
	// reserved bits dropped on write and read back as zero
	a_aux_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && sel_aux) |=> aux_converter_bits == $past(reg_wdata[5:0]))
		else $error("aux bits not written");
	a_read_timing: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_rd && reg_addr == 8'h4f) |=> reg_rdata[7:6] == 2'b00 && reg_rdata[5:0] == aux_r)
		else $error("aux read wrong");
	a_aprobe_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_rd && sel_ap) |=> reg_rdata[7:5] == 3'b000)
		else $error("analog reserved bits read set");
	a_dprobe_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_rd && sel_dp) |=> !reg_rdata[7])
		else $error("digital reserved bit read set");
	// read data must not linger, software polls with back to back reads
	a_read_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without strobe");
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the rx header and test select bank
// Assumes: plain strobe port, read data one cycle after the strobe
// Notes: register reads and writes go through tasks; no random stimulus
`include "rxtm_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rxtm_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic fixed_len_mode = 1'b0;
	logic [7:0] programmed_len = 8'h00;
	logic general_pin_zero = 1'b0;
	rxtm_capture_s cap = '0;
	logic [7:0] reg_rdata, expected_rx_len;
	logic [5:0] aux_converter_bits, digital_sel;
	logic [4:0] analog_sel, exp_sel;
	logic analog_route_valid, scan_mode, scan_shift_enable;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	rxtm_regs u_rxtm_regs (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_capture(cap), .fixed_len_mode(fixed_len_mode), .programmed_len(programmed_len),
		.expected_rx_len(expected_rx_len), .aux_converter_bits(aux_converter_bits),
		.analog_sel(analog_sel), .analog_route_valid(analog_route_valid),
		.digital_sel(digital_sel), .general_pin_zero(general_pin_zero),
		.scan_mode(scan_mode), .scan_shift_enable(scan_shift_enable));
	// 125 MHz clock
	always #4 core_clk = ~core_clk;
	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// request driven at a rising edge and taken at the next; the strobe drops on
	// the taking edge, so a following call leaves one idle edge, never a double drive
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(negedge core_clk);
	endtask
	// read data stands only in the cycle after the taking edge, so look mid-cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(what, exp, reg_rdata);
	endtask
	// hang guard, the sequence needs a few hundred cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			close_out();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`RXTM_OFF_HDR2, 8'h00, "hdr2 reset");
		rd(`RXTM_OFF_HDR1, 8'h00, "hdr1 reset");
		rd(`RXTM_OFF_HDR0, 8'h00, "hdr0 reset");
		rd(`RXTM_OFF_PLEN, 8'hff, "len reset");
		rd(`RXTM_OFF_AUX, 8'h00, "aux reset");
		rd(`RXTM_OFF_APROBE, 8'h00, "analog reset");
		rd(`RXTM_OFF_DPROBE, 8'h00, "digital reset");
		rd(8'h60, 8'h00, "unmapped");
		@(posedge core_clk);
		cap <= '{1'b1, 8'ha5, 8'h5a, 8'h3c, 8'h21};
		@(posedge core_clk);
		cap.valid <= 1'b0;
		// writes to the captured bytes must leave them alone
		for (int i = 0; i < 4; i++) wr(8'(8'h48 + i), 8'hff);
		rd(`RXTM_OFF_HDR2, 8'ha5, "hdr2");
		rd(`RXTM_OFF_HDR1, 8'h5a, "hdr1");
		rd(`RXTM_OFF_HDR0, 8'h3c, "hdr0");
		rd(`RXTM_OFF_PLEN, 8'h21, "len");
		@(posedge core_clk);
		programmed_len <= 8'h40;
		@(negedge core_clk);
		chk("len out", 8'h21, expected_rx_len);
		@(posedge core_clk);
		fixed_len_mode <= 1'b1;
		@(negedge core_clk);
		chk("len fixed", 8'h40, expected_rx_len);
		wr(`RXTM_OFF_AUX, 8'hff);
		chk("aux bits", 8'h3f, {2'b00, aux_converter_bits});
		rd(`RXTM_OFF_AUX, 8'h3f, "aux read");
		// every analog code, reserved bits set on each write
		for (int c = 0; c < 32; c++) begin
			wr(`RXTM_OFF_APROBE, {3'b111, 5'(c)});
			exp_sel = (c == 0 || (c >= 11 && c <= 17)) ? 5'h00 : 5'(c);
			chk("analog sel", {3'b000, exp_sel}, {3'b000, analog_sel});
			chk("route valid", {7'h00, exp_sel != 5'h00}, {7'h00, analog_route_valid});
			rd(`RXTM_OFF_APROBE, {3'b000, 5'(c)}, "analog read");
		end
		wr(`RXTM_OFF_DPROBE, 8'hff);
		chk("digital sel", 8'h3f, {2'b00, digital_sel});
		chk("scan mode", 8'h01, {7'h00, scan_mode});
		rd(`RXTM_OFF_DPROBE, 8'h7f, "digital read");
		// the pin crosses the synchroniser and shows after the fourth edge
		@(posedge core_clk);
		general_pin_zero <= 1'b1;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("scan early", 8'h00, {7'h00, scan_shift_enable});
		@(negedge core_clk);
		chk("scan on", 8'h01, {7'h00, scan_shift_enable});
		wr(`RXTM_OFF_DPROBE, 8'h15);
		chk("scan off", 8'h00, {7'h00, scan_shift_enable});
		chk("scan mode off", 8'h00, {7'h00, scan_mode});
		chk("digital sel2", 8'h15, {2'b00, digital_sel});
		// second reset in mid-run: written and captured values go back
		@(posedge core_clk);
		rst_n <= 1'b0;
		fixed_len_mode <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk("aux rereset", 8'h00, {2'b00, aux_converter_bits});
		chk("len out rereset", 8'hff, expected_rx_len);
		rd(`RXTM_OFF_HDR1, 8'h00, "hdr1 rereset");
		rd(`RXTM_OFF_PLEN, 8'hff, "len rereset");
		rd(`RXTM_OFF_APROBE, 8'h00, "analog rereset");
		rd(`RXTM_OFF_DPROBE, 8'h00, "digital rereset");
		close_out();
	end
endmodule
`default_nettype wire
